// File: hdl/sap_analyzer_cfg.sv
// Purpose: Storm policers, private-VLAN masking, aging timer and table
//          options of the frame analyzer, with their APB registers.
// Assumes: Frame and table inputs are synchronous to pclk.
// Notes:   Table storage and the lookup engine sit outside this block.
//
// Register access over APB and the placing of the registers were decided locally.
`default_nettype none

module sap_analyzer_cfg
    import sap_pkg::*;
#(
    parameter int          ADDR_W        = 8,
    parameter int          ENTRY_W       = 64,
    parameter int          ROW_W         = 11,
    parameter int unsigned SECOND_CYCLES = SECOND_CYC
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 frame_valid,
    input  wire logic [1:0]           frame_class,
    input  wire logic                 frame_to_cpu,
    input  wire logic                 frame_to_front,
    output logic                      frame_drop,
    input  wire logic [11:0]          vlan_mask,
    input  wire logic                 private_lan_marker,
    input  wire logic [1:0]           port_kind,
    output logic      [11:0]          fwd_mask,
    output logic                      age_scan_start,
    input  wire logic                 scan_entry_valid,
    input  wire logic                 scan_entry_locked,
    input  wire logic                 scan_entry_aged,
    output logic                      entry_remove,
    output logic                      entry_set_aged,
    input  wire logic                 age_pass_done,
    input  wire logic [ROW_W-1:0]     lookup_row_in,
    output logic      [ROW_W-1:0]     lookup_row,
    input  wire logic                 rd_req,
    input  wire logic [1:0]           rd_bucket,
    input  wire logic [4*ENTRY_W-1:0] rd_row_data,
    output logic      [ENTRY_W-1:0]   rd_data,
    output logic                      rd_valid
);

    // ======================================================================
    // State record: every flip-flop of the block.
    typedef struct packed {
        logic [31:0]                 prdata;
        logic                        pready;
        logic                        pslverr;
        logic [3:0]                  burst;
        logic [3:0][3:0]             rate;
        logic [3:0]                  unit;
        logic [3:0][1:0]             mode;
        logic [11:0]                 isol;
        logic [11:0]                 grp;
        logic                        age_fast;
        logic [19:0]                 age_period;
        logic                        pinned;
        logic                        reduced;
        logic                        shadow_en;
        logic                        ev_scan;
        logic                        ev_storm;
        logic [3:0][12:0]            tokens;
        logic [3:0][27:0]            acc;
        logic [27:0]                 tb_cnt;
        logic [19:0]                 unit_cnt;
        logic                        scan;
        logic                        drop;
        logic [11:0]                 fwd;
        logic                        remove;
        logic                        set_aged;
        logic [ROW_W-1:0]            row;
        logic [2:0][ENTRY_W-1:0]     shadow;
        logic [ENTRY_W-1:0]          rd_data;
        logic                        rd_valid;
    } sap_state_t;

    sap_state_t st_ff;
    sap_state_t nxt_st;

    // ======================================================================
    // Helpers.

    // Bucket depth; exponents above twelve are held at the 4096 ceiling.
    function automatic logic [12:0] bucket_depth(input logic [3:0] e);
        if (e >= MAX_BURST_EXP) begin
            return MAX_BURST;
        end
        return 13'h0001 << e;
    endfunction

    // Frames per second that one policer earns.
    function automatic logic [24:0] rate_fps(input logic [3:0] e,
                                             input logic       unit);
        logic [24:0] base;
        base = unit ? 25'h0000001 : 25'(KILO);
        return base << e;
    endfunction

    localparam logic [27:0] SEC_LEN  = 28'(SECOND_CYCLES);
    localparam logic [27:0] FAST_LEN = 28'(FAST_UNIT_CYC);

    logic              apb_first;
    logic              apb_done;
    logic              hit;
    logic [31:0]       rdw;
    logic [7:0]        a8;
    logic [12:0]       depth;
    logic [12:0]       tok;
    logic [28:0]       sum;
    logic              policed;
    logic [27:0]       unit_len;
    logic [19:0]       period_eff;
    logic [ENTRY_W-1:0] live_sel;

    // Helpers for the checks below; shadow_sel also feeds the read path.
    logic               sel_empty;
    logic               sel_mode_off;
    logic [ENTRY_W-1:0] live1;
    logic [ENTRY_W-1:0] shadow_sel;
    assign sel_empty    = (st_ff.tokens[frame_class] == 13'h0000);
    assign sel_mode_off = (st_ff.mode[frame_class] == MODE_OFF);
    assign live1        = rd_row_data[2*ENTRY_W-1:ENTRY_W];
    assign shadow_sel   = st_ff.shadow[rd_bucket - 2'h1];

    // ======================================================================
    // Next-state logic.
    always_comb begin
        nxt_st   = st_ff;
        hit      = 1'b1;
        rdw      = 32'h00000000;
        depth    = bucket_depth(st_ff.burst);
        tok      = 13'h0000;
        sum      = 29'h00000000;
        policed  = 1'b0;
        live_sel = '0;
        a8       = 8'(paddr);

        nxt_st.pready   = 1'b0;
        nxt_st.pslverr  = 1'b0;
        nxt_st.drop     = 1'b0;
        nxt_st.scan     = 1'b0;
        nxt_st.remove   = 1'b0;
        nxt_st.set_aged = 1'b0;
        nxt_st.rd_valid = 1'b0;

        // The answer comes one cycle into the access phase; the extra cycle
        // lets read data come straight from a flip-flop.
        apb_first = psel && penable && !st_ff.pready;
        apb_done  = psel && penable && st_ff.pready;

        if (a8 == OFF_BURST) begin
            rdw[BURST_MSB:0] = st_ff.burst;
        end else if (a8 == OFF_CFG0) begin
            rdw[6:0] = {st_ff.rate[0], st_ff.unit[0], st_ff.mode[0]};
        end else if (a8 == OFF_CFG1) begin
            rdw[6:0] = {st_ff.rate[1], st_ff.unit[1], st_ff.mode[1]};
        end else if (a8 == OFF_CFG2) begin
            rdw[6:0] = {st_ff.rate[2], st_ff.unit[2], st_ff.mode[2]};
        end else if (a8 == OFF_CFG3) begin
            rdw[6:0] = {st_ff.rate[3], st_ff.unit[3], st_ff.mode[3]};
        end else if (a8 == OFF_ISOL) begin
            rdw[11:0] = st_ff.isol;
        end else if (a8 == OFF_GROUP) begin
            rdw[11:0] = st_ff.grp;
        end else if (a8 == OFF_AGING) begin
            rdw[AGE_FAST_BIT]             = st_ff.age_fast;
            rdw[AGE_PER_MSB:AGE_PER_LSB]  = st_ff.age_period;
            rdw[PINNED_BIT]               = st_ff.pinned;
        end else if (a8 == OFF_OPTIONS) begin
            rdw[REDUCED_BIT] = st_ff.reduced;
            rdw[SHADOW_BIT]  = st_ff.shadow_en;
        end else if (a8 == OFF_EVENTS) begin
            rdw[EV_SCAN_BIT]  = st_ff.ev_scan;
            rdw[EV_STORM_BIT] = st_ff.ev_storm;
        end else begin
            hit = 1'b0;
        end
        if (paddr > ADDR_W'(8'hFF)) begin
            hit = 1'b0;
        end

        if (apb_first) begin
            nxt_st.pready  = 1'b1;
            nxt_st.pslverr = !hit;
            nxt_st.prdata  = pwrite ? 32'h00000000 : rdw;
        end

        // Writes land on the edge that completes the access.
        if (apb_done && pwrite && !st_ff.pslverr) begin
            if (a8 == OFF_BURST) begin
                nxt_st.burst = pwdata[BURST_MSB:0];
            end else if (a8 == OFF_CFG0) begin
                nxt_st.rate[0] = pwdata[RATE_MSB:RATE_LSB];
                nxt_st.unit[0] = pwdata[UNIT_BIT];
                nxt_st.mode[0] = pwdata[MODE_MSB:0];
            end else if (a8 == OFF_CFG1) begin
                nxt_st.rate[1] = pwdata[RATE_MSB:RATE_LSB];
                nxt_st.unit[1] = pwdata[UNIT_BIT];
                nxt_st.mode[1] = pwdata[MODE_MSB:0];
            end else if (a8 == OFF_CFG2) begin
                nxt_st.rate[2] = pwdata[RATE_MSB:RATE_LSB];
                nxt_st.unit[2] = pwdata[UNIT_BIT];
                nxt_st.mode[2] = pwdata[MODE_MSB:0];
            end else if (a8 == OFF_CFG3) begin
                nxt_st.rate[3] = pwdata[RATE_MSB:RATE_LSB];
                nxt_st.unit[3] = pwdata[UNIT_BIT];
                nxt_st.mode[3] = pwdata[MODE_MSB:0];
            end else if (a8 == OFF_ISOL) begin
                nxt_st.isol = pwdata[11:0];
            end else if (a8 == OFF_GROUP) begin
                nxt_st.grp = pwdata[11:0];
            end else if (a8 == OFF_AGING) begin
                nxt_st.age_fast   = pwdata[AGE_FAST_BIT];
                nxt_st.age_period = pwdata[AGE_PER_MSB:AGE_PER_LSB];
                nxt_st.pinned     = pwdata[PINNED_BIT];
            end else if (a8 == OFF_OPTIONS) begin
                nxt_st.reduced   = pwdata[REDUCED_BIT];
                nxt_st.shadow_en = pwdata[SHADOW_BIT];
            end else if (a8 == OFF_EVENTS) begin
                // Write one to clear; a new event below still wins.
                nxt_st.ev_scan  = st_ff.ev_scan & ~pwdata[EV_SCAN_BIT];
                nxt_st.ev_storm = st_ff.ev_storm & ~pwdata[EV_STORM_BIT];
            end
        end

        for (int i = 0; i < NUM_POLICERS; i++) begin
            tok = st_ff.tokens[i];
            sum = {1'b0, st_ff.acc[i]} +
                  {4'h0, rate_fps(st_ff.rate[i], st_ff.unit[i])};
            if (sum >= {1'b0, SEC_LEN}) begin
                nxt_st.acc[i] = 28'(sum - {1'b0, SEC_LEN});
                if (tok < depth) begin
                    tok = tok + 13'h0001;
                end
            end else begin
                nxt_st.acc[i] = sum[27:0];
            end
            if (tok > depth) begin
                tok = depth;
            end
            policed = (st_ff.mode[i][0] && frame_to_cpu) ||
                      (st_ff.mode[i][1] && frame_to_front);
            if (frame_valid && frame_class == 2'(i) && policed) begin
                if (tok == 13'h0000) begin
                    nxt_st.drop = 1'b1;
                end else begin
                    tok = tok - 13'h0001;
                end
            end
            nxt_st.tokens[i] = tok;
        end

        nxt_st.ev_storm = nxt_st.ev_storm | nxt_st.drop;
        nxt_st.ev_scan = nxt_st.ev_scan | age_pass_done;

        if (!private_lan_marker) begin
            nxt_st.fwd = vlan_mask;
        end else begin
            case (port_kind)
                KIND_PROMISC: nxt_st.fwd = vlan_mask;
                KIND_COMMUNITY: nxt_st.fwd = vlan_mask & st_ff.isol;
                default: nxt_st.fwd = vlan_mask & st_ff.grp & st_ff.isol;
            endcase
        end

        unit_len   = st_ff.age_fast ? FAST_LEN : SEC_LEN;
        period_eff = (st_ff.age_fast && st_ff.age_period < FAST_AGE_MIN) ?
                     FAST_AGE_MIN : st_ff.age_period;
        if (st_ff.age_period == 20'h00000) begin
            nxt_st.tb_cnt   = 28'h0000000;
            nxt_st.unit_cnt = 20'h00000;
        end else if (st_ff.tb_cnt + 28'h0000001 >= unit_len) begin
            nxt_st.tb_cnt = 28'h0000000;
            if (st_ff.unit_cnt + 20'h00001 >= period_eff) begin
                nxt_st.unit_cnt = 20'h00000;
                nxt_st.scan     = 1'b1;
            end else begin
                nxt_st.unit_cnt = st_ff.unit_cnt + 20'h00001;
            end
        end else begin
            nxt_st.tb_cnt = st_ff.tb_cnt + 28'h0000001;
        end

        // A first scan marks an idle unlocked entry, the next one removes it.
        if (scan_entry_valid) begin
            nxt_st.remove   = !scan_entry_locked && scan_entry_aged;
            nxt_st.set_aged = !scan_entry_aged &&
                              (!scan_entry_locked || st_ff.pinned);
        end

        nxt_st.row = st_ff.reduced ?
                     (lookup_row_in & ROW_W'((1 << ROW_RED_W) - 1)) :
                     lookup_row_in;

        live_sel = rd_row_data[rd_bucket*ENTRY_W +: ENTRY_W];
        if (rd_req) begin
            nxt_st.rd_valid = 1'b1;
            if (st_ff.shadow_en && rd_bucket == 2'h0) begin
                nxt_st.shadow  = rd_row_data[4*ENTRY_W-1:ENTRY_W];
                nxt_st.rd_data = live_sel;
            end else if (st_ff.shadow_en) begin
                nxt_st.rd_data = shadow_sel;
            end else begin
                nxt_st.rd_data = live_sel;
            end
        end
    end

    // ======================================================================
    // State register; both port masks come up all ones.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff      <= '0;
            st_ff.isol <= MASK_RST;
            st_ff.grp  <= MASK_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata         = st_ff.prdata;
    assign pready         = st_ff.pready;
    assign pslverr        = st_ff.pslverr;
    assign frame_drop     = st_ff.drop;
    assign fwd_mask       = st_ff.fwd;
    assign age_scan_start = st_ff.scan;
    assign entry_remove   = st_ff.remove;
    assign entry_set_aged = st_ff.set_aged;
    assign lookup_row     = st_ff.row;
    assign rd_data        = st_ff.rd_data;
    assign rd_valid       = st_ff.rd_valid;

    // ======================================================================
    // Checks.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    burst_cap_a: assert property (
        $stable(st_ff.burst) |->
            st_ff.tokens[0] <= bucket_depth(st_ff.burst))
        else $error("policer bucket above burst depth");

    drop_empty_a: assert property (
        frame_drop |-> $past(sel_empty) && $past(frame_valid))
        else $error("discard without empty bucket");

    mode_off_a: assert property (
        frame_valid && sel_mode_off |=> !frame_drop)
        else $error("disabled policer discarded a frame");

    promisc_mask_a: assert property (
        private_lan_marker && port_kind == KIND_PROMISC
            |=> fwd_mask == $past(vlan_mask))
        else $error("promiscuous mask altered");

    community_mask_a: assert property (
        private_lan_marker && port_kind == KIND_COMMUNITY
            |=> fwd_mask == ($past(vlan_mask) & $past(st_ff.isol)))
        else $error("community mask wrong");

    isolated_mask_a: assert property (
        private_lan_marker && port_kind == KIND_ISOLATED
            |=> fwd_mask == ($past(vlan_mask) & $past(st_ff.grp)
                             & $past(st_ff.isol)))
        else $error("isolated mask wrong");

    public_mask_a: assert property (
        !private_lan_marker |=> fwd_mask == $past(vlan_mask))
        else $error("public VLAN mask altered");

    age_off_a: assert property (
        age_scan_start |-> $past(st_ff.age_period) != 20'h00000)
        else $error("scan started with aging disabled");

    locked_keep_a: assert property (
        scan_entry_valid && scan_entry_locked |=> !entry_remove &&
            entry_set_aged == ($past(st_ff.pinned) &&
                               !$past(scan_entry_aged)))
        else $error("locked entry handling wrong");

    scan_event_a: assert property (
        age_pass_done |=> st_ff.ev_scan)
        else $error("aging pass event lost");

    storm_event_a: assert property (
        frame_drop |-> st_ff.ev_storm)
        else $error("storm event not set");

    shadow_cap_a: assert property (
        rd_req && st_ff.shadow_en && rd_bucket == 2'h0
            |=> st_ff.shadow[0] == $past(live1))
        else $error("bucket 1 not captured");

    shadow_read_a: assert property (
        rd_req && st_ff.shadow_en && rd_bucket != 2'h0
            |=> rd_data == $past(shadow_sel))
        else $error("shadow read returned live data");

endmodule

`default_nettype wire

// File: hdl/sap_pkg.sv
// Purpose: Shared constants for the analyzer policing, aging and table slice.
// Assumes: One 200 MHz clock; APB registers take one aligned word each.
// Notes:   Offsets, field positions, reset values and cycle counts live here.
`default_nettype none

package sap_pkg;

    // ======================================================================
    // Register byte offsets.
    localparam logic [7:0] OFF_BURST   = 8'h00;
    localparam logic [7:0] OFF_CFG0    = 8'h04;
    localparam logic [7:0] OFF_CFG1    = 8'h08;
    localparam logic [7:0] OFF_CFG2    = 8'h0C;
    localparam logic [7:0] OFF_CFG3    = 8'h10;
    localparam logic [7:0] OFF_ISOL    = 8'h14;
    localparam logic [7:0] OFF_GROUP   = 8'h18;
    localparam logic [7:0] OFF_AGING   = 8'h1C;
    localparam logic [7:0] OFF_OPTIONS = 8'h20;
    localparam logic [7:0] OFF_EVENTS  = 8'h24;

    // ======================================================================
    // Field positions.
    localparam int BURST_MSB      = 3;
    localparam int RATE_MSB       = 6;
    localparam int RATE_LSB       = 3;
    localparam int UNIT_BIT       = 2;
    localparam int MODE_MSB       = 1;
    localparam int AGE_FAST_BIT   = 21;
    localparam int AGE_PER_MSB    = 20;
    localparam int AGE_PER_LSB    = 1;
    localparam int PINNED_BIT     = 0;
    localparam int REDUCED_BIT    = 1;
    localparam int SHADOW_BIT     = 0;
    localparam int EV_SCAN_BIT    = 24;
    localparam int EV_STORM_BIT   = 22;

    // ======================================================================
    // Reset values and limits.
    localparam logic [11:0] MASK_RST      = 12'hFFF;
    localparam logic [3:0]  MAX_BURST_EXP = 4'hC;
    localparam logic [12:0] MAX_BURST     = 13'h1000;
    localparam logic [19:0] FAST_AGE_MIN  = 20'h00003;
    localparam int          KILO          = 1000;
    localparam int          NUM_POLICERS  = 4;
    localparam int          ROW_RED_W     = 6;

    // Target modes and receive port kinds.
    localparam logic [1:0] MODE_OFF       = 2'h0;
    localparam logic [1:0] KIND_PROMISC   = 2'h0;
    localparam logic [1:0] KIND_COMMUNITY = 2'h1;
    localparam logic [1:0] KIND_ISOLATED  = 2'h2;

    // ======================================================================
    // Time base.
    localparam int CLK_PERIOD_NS = 5;
    localparam int FAST_UNIT_NS  = 13100;
    localparam int SECOND_NS     = 1000000000;
    localparam int FAST_UNIT_CYC = FAST_UNIT_NS / CLK_PERIOD_NS;
    localparam int SECOND_CYC    = SECOND_NS / CLK_PERIOD_NS;

endpackage

`default_nettype wire

// File: testbench/sap_analyzer_cfg_test.sv
// Purpose: Self-checking bench for the analyzer configuration slice.
// Assumes: APB answers with one wait state; one second is 1000 cycles.
// Notes:   Only mismatches and the verdict are printed.
`default_nettype none
module sap_analyzer_cfg_test import sap_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic frame_valid = 0, frame_to_cpu = 1, frame_to_front = 1;
    logic private_lan_marker = 0, age_pass_done = 0, rd_req = 0;
    logic scan_entry_valid = 0, scan_entry_locked = 0, scan_entry_aged = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic [1:0] frame_class = 0, port_kind = 0, rd_bucket = 0;
    logic [11:0] vlan_mask = 12'hAB5, fwd_mask;
    logic [10:0] lookup_row_in = 11'h7FF, lookup_row;
    logic [255:0] rowd = {64'h4, 64'h3, 64'h2, 64'h1};
    logic [63:0] rd_data;
    logic pready, pslverr, frame_drop, age_scan_start, rd_valid;
    logic entry_remove, entry_set_aged;
    logic [2:0] dr;
    int bad_count = 0, checks = 0, n;
    sap_analyzer_cfg #(.SECOND_CYCLES(1000)) i_sap_analyzer_cfg (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .frame_valid, .frame_class,
        .frame_to_cpu, .frame_to_front, .frame_drop, .vlan_mask,
        .private_lan_marker, .port_kind, .fwd_mask, .age_scan_start,
        .scan_entry_valid, .scan_entry_locked, .scan_entry_aged,
        .entry_remove, .entry_set_aged, .age_pass_done, .lookup_row_in,
        .lookup_row, .rd_req, .rd_bucket, .rd_row_data(rowd), .rd_data,
        .rd_valid);
    // ==========================================================
    // Tasks. Every driver change lands just after a rising edge.
    task automatic chk(input string s, input logic [63:0] g, x);
        checks++;
        if (g !== x) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", s, x, g);
        end
    endtask
    // The request is held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait count is assumed; only the watchdog ends a hung access.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(input string s, input logic [7:0] a,
                       input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(s, 64'(q), 64'(x));
    endtask
    task automatic pv(input logic m, input logic [1:0] k,
                      input logic [11:0] x);
        private_lan_marker <= m;
        port_kind <= k;
        repeat (2) @(posedge pclk);
        chk("fwd_mask", 64'(fwd_mask), 64'(x));
    endtask
    // Three frames back to back; each drop shows one edge later.
    task automatic frames(input logic [1:0] c, input logic [2:0] x);
        frame_class <= c;
        frame_valid <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            if (i == 2)
                frame_valid <= 1'b0;
            if (i > 0)
                dr[i-1] = frame_drop;
        end
        chk("frame_drop", 64'(dr), 64'(x));
    endtask
    task automatic rd(input logic [1:0] b, input logic [63:0] x);
        rd_req <= 1'b1;
        rd_bucket <= b;
        @(posedge pclk);
        rd_req <= 1'b0;
        @(posedge pclk);
        chk("rd_data", rd_data, x);
        chk("rd_valid", 64'(rd_valid), 64'h1);
    endtask
    task automatic ent(input logic l, ag, input logic [1:0] x);
        scan_entry_valid <= 1'b1;
        scan_entry_locked <= l;
        scan_entry_aged <= ag;
        @(posedge pclk);
        scan_entry_valid <= 1'b0;
        @(posedge pclk);
        chk("entry", 64'({entry_remove, entry_set_aged}), 64'(x));
    endtask
    // Waits for one scan pulse, then counts the cycles to the next one.
    task automatic gap(input string s, input int x);
        n = 0;
        while (age_scan_start !== 1'b1 && n < 3 * x) begin
            @(posedge pclk);
            n++;
        end
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (age_scan_start !== 1'b1 && n < 3 * x);
        chk(s, 64'(n), 64'(x));
    endtask
    task automatic results;
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // Clock, watchdog and the test sequence.
    initial forever #2.5 pclk = ~pclk;
    initial begin
        #300us;
        bad_count++;
        results;
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc("isolation", OFF_ISOL, 32'h00000FFF);
        rdc("group", OFF_GROUP, 32'h00000FFF);
        apb(1'b0, 8'h80, 32'h0);
        chk("pslverr", 64'(e), 64'h1);
        // Ports 0-3 promiscuous, 4-7 isolated, 8-11 community.
        apb(1'b1, OFF_ISOL, 32'h00000F0F);
        apb(1'b1, OFF_GROUP, 32'h000000FF);
        pv(1'b0, KIND_ISOLATED, 12'hAB5);
        pv(1'b1, KIND_PROMISC, 12'hAB5);
        pv(1'b1, KIND_COMMUNITY, 12'hA05);
        pv(1'b1, KIND_ISOLATED, 12'h005);
        // Two-frame burst, one frame per second, both destinations.
        apb(1'b1, OFF_BURST, 32'h1);
        apb(1'b1, OFF_CFG0, 32'h7);
        rdc("cfg0", OFF_CFG0, 32'h7);
        repeat (3000) @(posedge pclk);
        frames(2'h0, 3'b100);
        frames(2'h1, 3'b000);
        apb(1'b1, OFF_CFG0, 32'h5);
        frame_to_cpu <= 1'b0;
        frames(2'h0, 3'b000);
        rdc("events", OFF_EVENTS, 32'h00400000);
        apb(1'b1, OFF_EVENTS, 32'h00400000);
        age_pass_done <= 1'b1;
        @(posedge pclk);
        age_pass_done <= 1'b0;
        rdc("events", OFF_EVENTS, 32'h01000000);
        apb(1'b1, OFF_OPTIONS, 32'h3);
        // The row register follows the new option one edge later.
        @(posedge pclk);
        chk("lookup_row", 64'(lookup_row), 64'h3F);
        rd(2'h0, 64'h1);
        rowd <= {4{64'hF}};
        rd(2'h2, 64'h3);
        apb(1'b1, OFF_AGING, 32'h3);
        gap("scan_gap", 1000);
        ent(1'b0, 1'b1, 2'b10);
        ent(1'b1, 1'b0, 2'b01);
        // Fast units with the smallest legal interval of three.
        apb(1'b1, OFF_AGING, 32'h00200007);
        gap("fast_gap", 3 * FAST_UNIT_CYC);
        results;
    end
endmodule
`default_nettype wire
